// ### hdl/lips_seq.sv
// The AHB-Lite register port and the register offsets were decided locally.
`include "lips_params.svh"
module lips_seq
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Synchronous comparator results
    input  wire logic        supply_ok_hi,
    input  wire logic        supply_ok_lo,
    input  wire logic        enable_hi,
    input  wire logic        enable_lo,
    input  wire logic        gate_off,
    input  wire logic        filter_low,
    input  wire logic        fault_high,
    input  wire logic        sense_over,
    input  wire logic        fast_trip,
    input  wire logic        slow_trip,
    input  wire logic        output_monitor_comparator,
    // Drive outputs
    output logic             gate_drive_en,
    output logic             gate_pulldown_en,
    output logic             servo_en,
    output logic             timer_pulldown_switch,
    output logic             filter_pulldown_en,
    output logic             fast_armed,
    output logic             slow_armed,
    output logic             power_good,
    output logic             sys_rst_n,
    output logic             fault_n,
    output logic             irq
);
    import lips_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed
    {
        lips_state_e           fsm;     // Sequencer state
        logic                  rst_n;   // Reset output
        logic                  pgood;   // Filtered feedback good
        logic                  fault_n; // Fault output, low latched
        logic                  fast;    // Fast breaker armed
        logic                  slow;    // Slow breaker armed
        logic                  servo;   // Current-limit servo
        logic                  rtmr;    // Reset-release timing started, stays set after release
        logic [`LIPS_CNT_W-1:0] rcnt;   // Reset-release count
        logic [`LIPS_GF_W-1:0] gcnt;    // Glitch filter count
        logic [15:0]           ccnt;    // Enable-low clearing count
        logic                  dph;     // Bus data phase pending
        logic                  dwr;     // Data phase is a write
        logic [11:0]           dad;     // Data phase address
        logic [31:0]           rdata;   // Read data
        logic                  cena;    // Software enable
        logic [`LIPS_CNT_W-1:0] period; // Timing period in cycles
        logic [`LIPS_GF_W-1:0] gflt;    // Glitch filter length
        logic [`LIPS_NIRQ-1:0] ist;     // Sticky events
        logic [`LIPS_NIRQ-1:0] imask;   // Interrupt mask
    } lips_seq_s;

    lips_seq_s   s;
    lips_seq_s   n;
    lips_tmr_if  tif();
    logic [`LIPS_NIRQ-1:0] ev;

    // Shared timer, one period per cycle of the sequence
    lips_timer u_tmr
    (
        .clk  (clk),
        .nrst (nrst),
        .t    (tif)
    );

    // Timer runs in the two timing cycles only; reset release keeps its own count
    assign tif.run    = (s.fsm == LIPS_TMR1) || (s.fsm == LIPS_SOFT);
    assign tif.period = s.period;

    // Address decode used by the read address phase
    function automatic logic known(input logic [11:0] a);
        known = (a == `LIPS_A_CTRL) || (a == `LIPS_A_STAT) || (a == `LIPS_A_IRQ)
              || (a == `LIPS_A_MASK) || (a == `LIPS_A_PERIOD)
              || (a == `LIPS_A_GLITCH);
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        n  = s;
        ev = '0;
        case (s.fsm)
            LIPS_LOCK:
            begin
                // Leave lockout only above the upper threshold
                if (supply_ok_hi)
                    n.fsm = LIPS_WAIT;
            end
            LIPS_WAIT:
            begin
                // Gate must be seen off once supply and enable are good
                if (supply_ok_hi && enable_hi && s.cena && gate_off)
                    n.fsm = LIPS_TMR1;
            end
            LIPS_TMR1:
            begin
                if (tif.done)
                    n.fsm = LIPS_CHK;
            end
            LIPS_CHK:
            begin
                // Filter low and fault high needed for soft-start
                if (filter_low && fault_high)
                begin
                    n.fsm  = LIPS_SOFT;
                    n.fast = 1'b1;
                end
            end
            LIPS_SOFT:
            begin
                if (sense_over)
                    n.servo = 1'b1;
                else
                    n.servo = 1'b0;
                if (tif.done && n.fsm == LIPS_SOFT)
                begin
                    n.fsm   = LIPS_MON;
                    n.slow  = 1'b1;
                    n.servo = 1'b0;
                end
            end
            LIPS_MON:
            begin
                if (!enable_lo)
                begin
                    n.fsm  = LIPS_OFF;
                    n.fast = 1'b0;
                    n.slow = 1'b0;
                    ev[`LIPS_I_OFF] = 1'b1;
                end
            end
            LIPS_OFF:
            begin
                if (enable_hi)
                    n.fsm = LIPS_WAIT;
            end
            LIPS_FAULT:
            begin
                // Fault clears only after a long unbroken enable low
                if (enable_lo)
                    n.ccnt = '0;
                else if (s.ccnt >= 16'(`LIPS_CLR_CYC - 1))
                begin
                    n.fault_n = 1'b1;
                    n.fsm     = LIPS_OFF;
                end
                else
                    n.ccnt = s.ccnt + 1'b1;
            end
            default:
                n.fsm = LIPS_LOCK;
        endcase
        // Armed trip latches a fault; after the state step so no move hides it
        if ((s.fast && fast_trip) || (s.slow && slow_trip))
        begin
            n.fsm     = LIPS_FAULT;
            n.fault_n = 1'b0;
            n.fast    = 1'b0;
            n.slow    = 1'b0;
            n.servo   = 1'b0;
            ev[`LIPS_I_FAULT] = 1'b1;
        end
        if (n.fsm != LIPS_FAULT)
            n.ccnt = '0;
        // Low supply overrides everything
        if (!supply_ok_lo)
        begin
            n.fsm   = LIPS_LOCK;
            n.fast  = 1'b0;
            n.slow  = 1'b0;
            n.servo = 1'b0;
            ev[`LIPS_I_LOCK] = (s.fsm != LIPS_LOCK);
        end

        // Glitch filter: flips only after gflt+1 disagreeing cycles in a row,
        // so a short dip never reaches the reset output
        if (output_monitor_comparator != s.pgood)
            n.gcnt = '0;
        else if (s.gcnt >= s.gflt)
        begin
            n.gcnt  = '0;
            n.pgood = !output_monitor_comparator;
        end
        else
            n.gcnt = s.gcnt + 1'b1;
        ev[`LIPS_I_PGOOD] = n.pgood && !s.pgood;

        // Reset release: at the end of soft-start, else after one full timing period of good feedback
        if (!s.pgood || n.fsm == LIPS_LOCK || n.fsm == LIPS_WAIT
            || n.fsm == LIPS_TMR1 || n.fsm == LIPS_CHK
            || n.fsm == LIPS_SOFT)
        begin
            n.rst_n = 1'b0;
            n.rtmr  = 1'b0;
            n.rcnt  = '0;
        end
        else if (s.fsm == LIPS_SOFT && n.fsm == LIPS_MON)
            n.rst_n = 1'b1;
        else if (!s.rst_n)
        begin
            n.rtmr = 1'b1;
            if (s.rcnt + 1'b1 >= s.period)
                n.rst_n = 1'b1;
            else
                n.rcnt = s.rcnt + 1'b1;
        end
        ev[`LIPS_I_RSTREL] = n.rst_n && !s.rst_n;

        // Bus data phase: write or read completes
        if (s.dph && s.dwr)
        begin
            case (s.dad)
                `LIPS_A_CTRL:   n.cena   = hwdata[0];
                `LIPS_A_MASK:   n.imask  = hwdata[`LIPS_NIRQ-1:0];
                `LIPS_A_PERIOD: n.period = hwdata[`LIPS_CNT_W-1:0];
                `LIPS_A_GLITCH: n.gflt   = hwdata[`LIPS_GF_W-1:0];
                default:        n.cena   = s.cena;
            endcase
        end
        if (s.dph && !s.dwr && s.dad == `LIPS_A_IRQ)
            n.ist = ev;      // Read clears, new events still land
        else
            n.ist = s.ist | ev;
        // Bus address phase
        n.dph = hsel && hready && htrans[1];
        n.dwr = hwrite;
        n.dad = haddr;
        n.rdata = '0;
        if (n.dph && !hwrite && known(haddr))
        begin
            case (haddr)
                `LIPS_A_CTRL:   n.rdata = {31'h0, s.cena};
                `LIPS_A_STAT:   n.rdata = {20'h0, s.fsm, s.servo, s.slow,
                                           s.fast, s.pgood, s.rst_n, s.fault_n,
                                           gate_drive_en, 1'b0};
                `LIPS_A_IRQ:    n.rdata = {27'h0, s.ist | ev};
                `LIPS_A_MASK:   n.rdata = {27'h0, s.imask};
                `LIPS_A_PERIOD: n.rdata = {7'h0, s.period};
                default:        n.rdata = {24'h0, s.gflt};
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s         <= '0;
            s.fsm     <= LIPS_LOCK;
            s.fault_n <= 1'b1;
            s.cena    <= 1'b1;
            s.period  <= `LIPS_CNT_W'(`LIPS_TMR_DEF_US * `LIPS_CLK_MHZ);
            s.gflt    <= `LIPS_GF_W'(`LIPS_GLITCH_DEF);
        end
        else
            s <= n;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Gate is driven only in soft-start and monitoring
    assign gate_drive_en    = (s.fsm == LIPS_SOFT) || (s.fsm == LIPS_MON);
    assign gate_pulldown_en = !gate_drive_en;
    assign servo_en         = s.servo;
    assign timer_pulldown_switch = !tif.busy;
    assign filter_pulldown_en    = 1'b1;
    assign fast_armed = s.fast;
    assign slow_armed = s.slow;
    assign power_good = s.pgood;
    assign sys_rst_n  = s.rst_n;
    assign fault_n    = s.fault_n;
    assign irq        = |(s.ist & s.imask);
    assign hrdata     = s.rdata;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence soft_entry;
        s.fsm == LIPS_CHK && filter_low && fault_high && supply_ok_lo
            && !(s.fast && fast_trip);
    endsequence

    soft_arm_a: assert property (@(posedge clk) disable iff (!nrst)
        soft_entry |=> s.fsm == LIPS_SOFT && s.fast && gate_drive_en)
        else $error("soft-start not entered with fast breaker armed");
    chk_block_a: assert property (@(posedge clk) disable iff (!nrst)
        s.fsm == LIPS_CHK && !(filter_low && fault_high) |=> s.fsm != LIPS_SOFT)
        else $error("soft-start began with bad filter or fault");
    lock_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        !supply_ok_lo |=> s.fsm == LIPS_LOCK && gate_pulldown_en)
        else $error("lockout did not pull the gate low");
    wait_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        s.fsm == LIPS_WAIT && !gate_off |=> s.fsm != LIPS_TMR1)
        else $error("timer started with gate on");
    off_entry_a: assert property (@(posedge clk) disable iff (!nrst)
        s.fsm == LIPS_MON && !enable_lo && supply_ok_lo && !(s.slow && slow_trip)
            && !(s.fast && fast_trip) |=> s.fsm == LIPS_OFF && !gate_drive_en)
        else $error("enable low did not start power-off");
    rst_low_a: assert property (@(posedge clk) disable iff (!nrst)
        !s.pgood |=> !s.rst_n)
        else $error("reset released without good feedback");
    servo_sense_a: assert property (@(posedge clk) disable iff (!nrst)
        s.fsm == LIPS_SOFT && $past(s.fsm) == LIPS_SOFT && sense_over
            && !tif.done && supply_ok_lo && !(s.fast && fast_trip)
            |=> s.servo)
        else $error("servo not engaged on overcurrent");
    glitch_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        s.pgood && s.gcnt == '0 && s.gflt != '0 && output_monitor_comparator
            |=> s.pgood)
        else $error("glitch filter passed a short pulse");
    mon_slow_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(s.fsm == LIPS_MON) |-> s.slow)
        else $error("slow breaker not armed in monitor mode");
    fault_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(s.fault_n) && $past(s.fsm) == LIPS_FAULT |-> !enable_lo)
        else $error("fault cleared without enable low");
endmodule

// ### hdl/lips_params.svh
`ifndef LIPS_PARAMS_SVH
`define LIPS_PARAMS_SVH
// What this block does
// - Timer node grounded when off, ramps when on
// - Threshold reached ends period, node to ground
// - Period length configurable as any 25-bit count of cycles
// - Wait for supply; gate, timer, filter low
// - Supply and enable valid, gate off, start timer
// - Second cycle only if filter low, fault high
// - Second cycle arms fast breaker, gate drive on
// - End: reset released, slow armed, monitor mode
// - Enable low in monitor mode starts power-off, gate pulled down
// - Power-off: output low drives reset low
// - Soft-start overcurrent engages current-limit servo
// - Servo released when current drops, ramp continues
// - Monitor comparator filtered against short glitches
// - Reset held low one full timing cycle
// - Fault clears after enable low 150us
// - Lockout on low supply pulls gate low

// ****************************************************************
// Clock and times
// ****************************************************************
`define LIPS_CLK_MHZ           100
`define LIPS_TMR_MIN_US        2000
`define LIPS_TMR_MAX_US        204000
`define LIPS_TMR_DEF_US        6200
`define LIPS_CLR_US            150
`define LIPS_CLR_CYC           (`LIPS_CLR_US * `LIPS_CLK_MHZ)
`define LIPS_GLITCH_DEF        16
`define LIPS_CNT_W             25
`define LIPS_GF_W              8

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define LIPS_A_CTRL            12'h000
`define LIPS_A_STAT            12'h004
`define LIPS_A_IRQ             12'h008
`define LIPS_A_MASK            12'h00C
`define LIPS_A_PERIOD          12'h010
`define LIPS_A_GLITCH          12'h014
`define LIPS_NIRQ              5
`define LIPS_I_PGOOD           0
`define LIPS_I_RSTREL          1
`define LIPS_I_FAULT           2
`define LIPS_I_OFF             3
`define LIPS_I_LOCK            4
`endif

// ### hdl/lips_pkg.sv
package lips_pkg;
    // Sequencer states, Gray coded in the listed order, not along the start-up path
    typedef enum logic [3:0]
    {
        LIPS_LOCK  = 4'h0,
        LIPS_WAIT  = 4'h1,
        LIPS_TMR1  = 4'h3,
        LIPS_SOFT  = 4'h2,
        LIPS_MON   = 4'h6,
        LIPS_OFF   = 4'h7,
        LIPS_FAULT = 4'h5,
        LIPS_CHK   = 4'h4
    } lips_state_e;
endpackage

// ### hdl/lips_tmr_if.sv
interface lips_tmr_if;
    logic        run;    // Timer enabled, node may ramp
    logic [24:0] period; // Period in cycles
    logic        done;   // One-cycle pulse at threshold
    logic        busy;   // Node above ground
    modport ctl (output run, output period, input done, input busy);
    modport tmr (input run, input period, output done, output busy);
endinterface

// ### hdl/lips_timer.sv
`include "lips_params.svh"
module lips_timer
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Sequencer side
    lips_tmr_if.tmr   t
);
    import lips_pkg::*;

    // ****************************************************************
    // Counter state: the timing node as a count
    // ****************************************************************
    typedef struct packed
    {
        logic [`LIPS_CNT_W-1:0] cnt;  // Node level
        logic                   done; // Threshold pulse
    } lips_tmr_s;

    lips_tmr_s st_reg;
    lips_tmr_s st_next;

    // Ramp while enabled, ground when off or at threshold
    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (!t.run)
        begin
            st_next.cnt = '0;
        end
        else if (st_reg.cnt + 1'b1 >= t.period)
        begin
            st_next.cnt  = '0;
            st_next.done = 1'b1;
        end
        else
        begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!nrst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign t.done = st_reg.done;
    assign t.busy = (st_reg.cnt != '0);

    // Node must be at ground in the cycle of the pulse, and while off
    node_ground_a: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.done |-> st_reg.cnt == '0)
        else $error("timer node not grounded at threshold");
    off_ground_a: assert property (@(posedge clk) disable iff (!nrst)
        !t.run |=> st_reg.cnt == '0)
        else $error("timer node not held low while off");
endmodule

// ### tb/lips_load_model.sv
module lips_load_model
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Sequencer drive and bench fault request
    input  wire logic gate_drive_en,
    input  wire logic force_bad,
    // Sensed results back to the sequencer
    output logic      gate_off,
    output logic      sense_over,
    output logic      output_monitor_comparator
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] lvl_reg; // Output level, 0 empty to 31 full

    // Gate on charges the load, gate off drains it, one step a cycle
    always_ff @(posedge clk)
    begin
        if (!nrst)
            lvl_reg <= 5'h00;
        else if (gate_drive_en && lvl_reg != 5'h1F)
            lvl_reg <= lvl_reg + 5'h01;
        else if (!gate_drive_en && lvl_reg != 5'h00)
            lvl_reg <= lvl_reg - 5'h01;
    end

    // Gate counts as off only once fully drained
    assign gate_off = (lvl_reg == 5'h00);
    // Inrush spike early in the ramp only, so the servo must let go later
    assign sense_over = gate_drive_en && lvl_reg > 5'h03 && lvl_reg < 5'h0D;
    // High while the output sits below threshold
    assign output_monitor_comparator = (lvl_reg < 5'h14) || force_bad;
endmodule

// ### tb/tb.sv
`include "lips_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk, nrst, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, q;
    logic        supply_ok_hi, supply_ok_lo, enable_hi, enable_lo, gate_off;
    logic        filter_low, fault_high, sense_over, fast_trip, slow_trip;
    logic        output_monitor_comparator, force_bad;
    logic        gate_drive_en, gate_pulldown_en, servo_en, timer_pulldown_switch;
    logic        filter_pulldown_en, fast_armed, slow_armed, power_good;
    logic        sys_rst_n, fault_n, irq;
    wire logic   hready = hreadyout; // Single slave drives the bus ready
    int          num_errors, cmp_count, cyc, n;

    // Reset value table, address beside expected read
    typedef struct {logic [11:0] a; logic [31:0] e;} lips_row_s;
    lips_row_s rows [6] = '{'{`LIPS_A_CTRL, 32'h1}, '{`LIPS_A_STAT, 32'h4},
        '{`LIPS_A_PERIOD, 32'h975E0}, '{`LIPS_A_GLITCH, 32'h10},
        '{12'h020, 32'h0}, '{12'h7FC, 32'h0}};

    lips_seq i_lips_seq (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .supply_ok_hi, .supply_ok_lo,
        .enable_hi, .enable_lo, .gate_off, .filter_low, .fault_high, .sense_over,
        .fast_trip, .slow_trip, .output_monitor_comparator, .gate_drive_en,
        .gate_pulldown_en, .servo_en, .timer_pulldown_switch, .filter_pulldown_en,
        .fast_armed, .slow_armed, .power_good, .sys_rst_n, .fault_n, .irq);

    lips_load_model i_lips_load_model (.clk, .nrst, .gate_drive_en, .force_bad,
        .gate_off, .sense_over, .output_monitor_comparator);

    // ****************************************************************
    // Clock, timeout and helpers
    // ****************************************************************
    always #5 clk = ~clk;

    // Whole run is near 15500 cycles, so this only trips on a hang
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One single word transfer, address phase then data phase
    // Ready and read data are taken as they stand just before each edge
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do
        begin
            @(negedge clk);
            rdy = hready;
            @(posedge clk);
        end
        while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do
        begin
            @(negedge clk);
            rdy = hready;
            q = hrdata;
            @(posedge clk);
        end
        while (rdy !== 1'b1);
    endtask

    // Watched outputs, picked by number
    function automatic logic pick(input int w);
        case (w)
            0:       return gate_drive_en;
            1:       return sys_rst_n;
            2:       return power_good;
            3:       return fault_n;
            default: return servo_en;
        endcase
    endfunction

    // Bounded wait, sampled mid-cycle so the edge updates have landed
    task automatic wait_for(input int w, input logic v);
        n = 0;
        while (pick(w) !== v && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {clk, nrst, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        {supply_ok_hi, supply_ok_lo, enable_hi, enable_lo, filter_low} = '0;
        {fault_high, fast_trip, slow_trip, force_bad} = '0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        // Lockout outputs while the supply is absent
        chk(gate_pulldown_en, 1'h1);
        chk(timer_pulldown_switch, 1'h1);
        chk(filter_pulldown_en, 1'h1);
        chk({gate_drive_en, sys_rst_n, irq}, 3'h0);
        for (int i = 0; i < 6; i++)
        begin
            ahb(1'b0, rows[i].a, 32'h0);
            chk(q, rows[i].e);
            chk({31'h0, hresp}, 32'h0);
        end
        ahb(1'b1, `LIPS_A_PERIOD, 32'h32);
        ahb(1'b1, `LIPS_A_GLITCH, 32'h2);
        ahb(1'b1, `LIPS_A_MASK, 32'h1F);
        // Start with the fault level low: must stall after the first cycle
        @(posedge clk);
        {supply_ok_hi, supply_ok_lo, enable_hi, enable_lo, filter_low} <= 5'h1F;
        repeat (12) @(negedge clk);
        chk(timer_pulldown_switch, 1'h0);
        repeat (150) @(negedge clk);
        chk(gate_drive_en, 1'h0);
        @(posedge clk);
        fault_high <= 1'b1;
        wait_for(0, 1'b1);
        chk(n <= 5, 1'h1);
        chk({fast_armed, slow_armed}, 2'h2);
        wait_for(4, 1'b1);
        chk({servo_en, gate_drive_en}, 2'h3);
        wait_for(4, 1'b0);
        chk({sense_over, gate_drive_en}, 2'h1);
        wait_for(2, 1'b1);
        chk(sys_rst_n, 1'h0);
        wait_for(1, 1'b1);
        chk(slow_armed, 1'h1);
        ahb(1'b0, `LIPS_A_STAT, 32'h0);
        chk(q & 32'hF1E, 32'h61E);
        chk(irq, 1'h1);
        ahb(1'b0, `LIPS_A_IRQ, 32'h0);
        chk(q, 32'h3);
        ahb(1'b0, `LIPS_A_IRQ, 32'h0);
        chk(q, 32'h0);
        chk(irq, 1'h0);
        // One-cycle dip must not reach the reset output
        @(posedge clk);
        force_bad <= 1'b1;
        @(posedge clk);
        force_bad <= 1'b0;
        repeat (10)
        begin
            @(negedge clk);
            chk(sys_rst_n, 1'h1);
        end
        // Real dip, then a full period of good before release
        @(posedge clk);
        force_bad <= 1'b1;
        wait_for(1, 1'b0);
        chk(n <= 10, 1'h1);
        @(posedge clk);
        force_bad <= 1'b0;
        wait_for(1, 1'b1);
        chk(n >= 50 && n <= 62, 1'h1);
        ahb(1'b1, `LIPS_A_MASK, 32'h0);
        ahb(1'b0, `LIPS_A_IRQ, 32'h0);
        // Power-off with every event masked
        @(posedge clk);
        {enable_hi, enable_lo} <= 2'h0;
        wait_for(0, 1'b0);
        chk({n <= 3, gate_pulldown_en}, 2'h3);
        wait_for(1, 1'b0);
        chk({n <= 20, irq}, 2'h2);
        ahb(1'b0, `LIPS_A_IRQ, 32'h0);
        chk(q[`LIPS_I_OFF], 1'h1);
        ahb(1'b1, `LIPS_A_MASK, 32'h1F);
        // Restart: drain, then one full period before the gate turns on
        @(posedge clk);
        {enable_hi, enable_lo} <= 2'h3;
        wait_for(0, 1'b1);
        chk(n >= 50 && n <= 70, 1'h1);
        @(posedge clk);
        fast_trip <= 1'b1;
        @(posedge clk);
        fast_trip <= 1'b0;
        wait_for(3, 1'b0);
        chk({n <= 3, gate_drive_en, irq}, 3'h5);
        // Enable held low just short of, then past, the clearing time
        @(posedge clk);
        {enable_hi, enable_lo} <= 2'h0;
        repeat (14900) @(negedge clk);
        chk(fault_n, 1'h0);
        wait_for(3, 1'b1);
        chk(n <= 110, 1'h1);
        // Restart, then lose the supply with the gate on
        @(posedge clk);
        {enable_hi, enable_lo} <= 2'h3;
        wait_for(0, 1'b1);
        @(posedge clk);
        {supply_ok_hi, supply_ok_lo} <= 2'h0;
        wait_for(0, 1'b0);
        chk({n <= 3, gate_pulldown_en}, 2'h3);
        ahb(1'b0, `LIPS_A_STAT, 32'h0);
        chk(q[11:8], 4'h0);
        ahb(1'b0, `LIPS_A_IRQ, 32'h0);
        chk(q[`LIPS_I_LOCK], 1'h1);
        print_verdict();
    end
endmodule
